/* File: src/sar_adc_pkg.sv */
package sar_adc_pkg;

	// ---------------------------------------------------------------
	// result format
	// ---------------------------------------------------------------
	localparam int RESULT_BITS = 12;
	localparam int FRAME_BITS  = 16;
	localparam int BIT_IDX_W   = 4;
	localparam int FRAME_CNT_W = 5;
	localparam int ANALOG_W    = 14;
	localparam int CNT_W       = 8;
	localparam int START_PULSE_NUM_W  = 16;

	localparam logic [RESULT_BITS-1:0] CODE_ALL_ONES = 12'hfff;
	localparam logic [RESULT_BITS-1:0] CODE_ZERO     = 12'h000;
	localparam logic signed [ANALOG_W-1:0] LEVEL_FULL_SCALE = 14'sh0fff;
	localparam logic signed [ANALOG_W-1:0] LEVEL_GROUND     = 14'sh0000;
	localparam logic [BIT_IDX_W-1:0] BIT_IDX_END = 4'hc;
	localparam logic [BIT_IDX_W-1:0] BIT_IDX_MSB = 4'hb;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 100;
	localparam int ACQ_TIME_NS       = 500;
	localparam int RATE_KSPS         = 500;
	localparam int NS_PER_MS         = 1000000;
	localparam int SYNC_MARGIN       = 4;
	localparam int SCK_HALF_CYCLES   = 4;
	localparam int FIFO_DEPTH        = 2;

	// acquisition_time as a least time: round up
	localparam int ACQ_CYCLES =
		(ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// conversion_duration: sample period less acquisition, rounded up
	function automatic int start_pulse_cycles(input int ksps);
		int period_ns;
		period_ns = NS_PER_MS / ksps;
		return (period_ns - ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	endfunction

endpackage

/* File: src/sar_adc_link_if.sv */
`timescale 1ns/1ps
interface sar_adc_link_if;

	logic sck;
	logic start_pulse;
	logic serial_result_out;
	logic serial_result_oe_n;
	logic serial_result_line;

	// released line reads low, as if pulled down
	assign serial_result_line = serial_result_oe_n ? 1'b0 : serial_result_out;

	modport device (
		input  sck,
		input  start_pulse,
		output serial_result_out,
		output serial_result_oe_n
	);

	modport host (
		output sck,
		output start_pulse,
		input  serial_result_line
	);

endinterface

/* File: src/sar_adc_device.sv */
// Contract
// - start rising begins conversion, output goes Hi-Z
// - conversion done, sleep without host command
// - start falling enables output, shows result_msb
// - each shift clock fall advances one bit
// - host samples each bit on rising edge
// - after twelve bits, zeros while start low
// - sleep lasts only while start stays high
// - sample-and-hold holds while asleep
// - start falling wakes, sample-and-hold tracks
// - host keeps start low for acquisition time
// - internal clock times conversion per rate grade
// - each conversion yields a twelve bit result
// - host holds shift clock still while converting
// - low-power host reads after next start fall
// - fast host lowers start, reads at once
// - host may shift fast within bit timing
// - straight binary, clamped at both ends
`timescale 1ns/1ps
module sar_adc_device #(
	parameter int RATE_KSPS   = sar_adc_pkg::RATE_KSPS,
	parameter int START_PULSE_CYCLES = sar_adc_pkg::start_pulse_cycles(RATE_KSPS)
) (
	input  wire logic                                  i_clk_sys,
	input  wire logic                                  i_reset_n,
	sar_adc_link_if.device                             link,
	input  wire logic signed [sar_adc_pkg::ANALOG_W-1:0] i_analog_level,
	output logic [sar_adc_pkg::RESULT_BITS-1:0]        o_result,
	output logic                                       o_busy,
	output logic                                       o_sleeping,
	output logic                                       o_tracking,
	output logic                                       o_overrange,
	output logic                                       o_output_enabled,
	output logic [sar_adc_pkg::START_PULSE_NUM_W-1:0]         o_start_pulse_count
);

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_SLEEP = 2'b00,
		ST_ACQ   = 2'b01,
		ST_START_PULSE  = 2'b10
	} core_state_t;

	typedef struct packed {
		core_state_t                            state;
		logic                                   start_meta;
		logic                                   start_sync;
		logic                                   oe_n;
		logic [sar_adc_pkg::CNT_W-1:0]          cnt;
		logic [sar_adc_pkg::RESULT_BITS-1:0]    held;
		logic                                   held_clamped;
		logic [sar_adc_pkg::RESULT_BITS-1:0]    result;
		logic                                   overrange;
		logic [sar_adc_pkg::START_PULSE_NUM_W-1:0]     start_pulse_count;
	} core_t;

	typedef struct packed {
		logic [sar_adc_pkg::BIT_IDX_W-1:0]      bit_idx;
	} link_t;

	localparam core_t CORE_RESET = '{
		state:        ST_SLEEP,
		start_meta:   1'b1,
		start_sync:   1'b1,
		oe_n:         1'b1,
		cnt:          '0,
		held:         sar_adc_pkg::CODE_ZERO,
		held_clamped: 1'b0,
		result:       sar_adc_pkg::CODE_ZERO,
		overrange:    1'b0,
		start_pulse_count:   '0
	};

	// time base for a conversion, in internal clock cycles
	localparam logic [sar_adc_pkg::CNT_W-1:0] START_PULSE_LOAD =
		sar_adc_pkg::CNT_W'(START_PULSE_CYCLES - 1);

	core_t core_reg;
	core_t core_next;
	link_t link_reg;
	link_t link_next;

	// ---------------------------------------------------------------
	// input clamp
	// ---------------------------------------------------------------
	function automatic logic [sar_adc_pkg::RESULT_BITS-1:0] clamp_code(
		input logic signed [sar_adc_pkg::ANALOG_W-1:0] lvl
	);
		if (lvl < sar_adc_pkg::LEVEL_GROUND) begin
			return sar_adc_pkg::CODE_ZERO;
		end else if (lvl > sar_adc_pkg::LEVEL_FULL_SCALE) begin
			return sar_adc_pkg::CODE_ALL_ONES;
		end
		return lvl[sar_adc_pkg::RESULT_BITS-1:0];
	endfunction

	function automatic logic is_clamped(
		input logic signed [sar_adc_pkg::ANALOG_W-1:0] lvl
	);
		return (lvl < sar_adc_pkg::LEVEL_GROUND) ||
			(lvl > sar_adc_pkg::LEVEL_FULL_SCALE);
	endfunction

	// ---------------------------------------------------------------
	// core: internal oscillator domain
	// ---------------------------------------------------------------
	always_comb begin
		core_next = core_reg;
		core_next.start_meta = link.start_pulse;
		core_next.start_sync = core_reg.start_meta;
		// output follows start level: high -> released, low -> driven
		core_next.oe_n = core_reg.start_sync;
		case (core_reg.state)
			ST_SLEEP: begin
				// held stays frozen here
				if (!core_reg.start_sync) begin
					core_next.state = ST_ACQ;
				end
			end
			ST_ACQ: begin
				core_next.held = clamp_code(i_analog_level);
				core_next.held_clamped = is_clamped(i_analog_level);
				if (core_reg.start_sync) begin
					// last tracked value is the sample
					core_next.held = core_reg.held;
					core_next.held_clamped = core_reg.held_clamped;
					core_next.cnt = START_PULSE_LOAD;
					core_next.state = ST_START_PULSE;
				end
			end
			ST_START_PULSE: begin
				// start edges are ignored until the conversion ends
				if (core_reg.cnt == '0) begin
					core_next.result = core_reg.held;
					core_next.overrange = core_reg.held_clamped;
					core_next.start_pulse_count = core_reg.start_pulse_count +
						sar_adc_pkg::START_PULSE_NUM_W'(1);
					if (core_reg.start_sync) begin
						core_next.state = ST_SLEEP;
					end else begin
						core_next.state = ST_ACQ;
					end
				end else begin
					core_next.cnt = core_reg.cnt -
						sar_adc_pkg::CNT_W'(1);
				end
			end
			default: begin
				core_next.state = ST_SLEEP;
			end
		endcase
		if (!i_reset_n) begin
			core_next = CORE_RESET;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		core_reg <= core_next;
	end

	// ---------------------------------------------------------------
	// link: shift clock domain
	// ---------------------------------------------------------------
	// shift clock stands still outside frames, so the high start level
	// clears the bit index; the result word only changes while start is
	// high, hence it is quasi-static whenever this side reads it
	always_comb begin
		link_next = link_reg;
		if (link_reg.bit_idx != sar_adc_pkg::BIT_IDX_END) begin
			link_next.bit_idx = link_reg.bit_idx +
				sar_adc_pkg::BIT_IDX_W'(1);
		end
	end

	always_ff @(negedge link.sck or posedge link.start_pulse) begin
		if (link.start_pulse) begin
			link_reg <= '0;
		end else begin
			link_reg <= link_next;
		end
	end

	// ---------------------------------------------------------------
	// pins and status
	// ---------------------------------------------------------------
	always_comb begin
		link.serial_result_out = 1'b0;
		if (link_reg.bit_idx < sar_adc_pkg::BIT_IDX_END) begin
			// MSB first
			link.serial_result_out = core_reg.result[
				sar_adc_pkg::BIT_IDX_MSB - link_reg.bit_idx];
		end
	end

	// enable lags start by two sync stages and one register; the host
	// must not sample the line earlier than that
	assign link.serial_result_oe_n = core_reg.oe_n;
	assign o_result         = core_reg.result;
	assign o_busy           = core_reg.state == ST_START_PULSE;
	assign o_sleeping       = core_reg.state == ST_SLEEP;
	assign o_tracking       = core_reg.state == ST_ACQ;
	assign o_overrange      = core_reg.overrange;
	assign o_output_enabled = !core_reg.oe_n;
	assign o_start_pulse_count     = core_reg.start_pulse_count;

endmodule

/* File: src/sar_adc_host.sv */
`timescale 1ns/1ps
module sar_adc_host #(
	parameter int RATE_KSPS  = sar_adc_pkg::RATE_KSPS,
	parameter int START_PULSE_WAIT  = sar_adc_pkg::start_pulse_cycles(RATE_KSPS) +
		sar_adc_pkg::SYNC_MARGIN,
	parameter int ACQ_WAIT   = sar_adc_pkg::ACQ_CYCLES +
		sar_adc_pkg::SYNC_MARGIN,
	parameter int SCK_HALF   = sar_adc_pkg::SCK_HALF_CYCLES,
	parameter int WORD_W     = sar_adc_pkg::RESULT_BITS,
	parameter int FIFO_DEPTH = sar_adc_pkg::FIFO_DEPTH
) (
	input  wire logic              i_clk_sys,
	input  wire logic              i_reset_n,
	sar_adc_link_if.host           link,
	input  wire logic              i_req_valid,
	input  wire logic              i_req_fast,
	output logic                   o_req_ready,
	output logic                   o_word_valid,
	input  wire logic              i_word_ready,
	output logic [WORD_W-1:0]      o_word_data
);

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int FRAME = sar_adc_pkg::FRAME_BITS;
	localparam int FCW   = sar_adc_pkg::FRAME_CNT_W;
	localparam int CW    = sar_adc_pkg::CNT_W;

	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_ACQ   = 2'b01,
		H_SHIFT = 2'b10,
		H_START_PULSE  = 2'b11
	} host_state_t;

	typedef struct packed {
		host_state_t                       state;
		logic                              start;
		logic                              sck;
		logic                              fast;
		logic                              converted;
		logic                              read_done;
		logic [CW-1:0]                     cnt;
		logic [FCW-1:0]                    bits;
		logic [FRAME-1:0]                  shreg;
		logic                              sdo_meta;
		logic                              sdo_sync;
		logic [FIFO_DEPTH-1:0][WORD_W-1:0] mem;
		logic [PTR_W-1:0]                  wr_ptr;
		logic [PTR_W-1:0]                  rd_ptr;
		logic [PTR_W:0]                    fill;
	} host_t;

	localparam logic [CW-1:0]  ACQ_LOAD  = CW'(ACQ_WAIT - 1);
	localparam logic [CW-1:0]  START_PULSE_LOAD = CW'(START_PULSE_WAIT - 1);
	localparam logic [CW-1:0]  HALF_LOAD = CW'(SCK_HALF - 1);
	localparam logic [FCW-1:0] BITS_END  = FCW'(FRAME);
	localparam logic [PTR_W:0] FILL_FULL = (PTR_W + 1)'(FIFO_DEPTH);

	host_t r;
	host_t n;
	logic  push;
	logic  pop;

	// ---------------------------------------------------------------
	// sequencer and buffer
	// ---------------------------------------------------------------
	always_comb begin
		n = r;
		push = 1'b0;
		pop = o_word_valid && i_word_ready;
		n.sdo_meta = link.serial_result_line;
		n.sdo_sync = r.sdo_meta;
		case (r.state)
			H_IDLE: begin
				if (i_req_valid && o_req_ready) begin
					n.fast = i_req_fast;
					n.read_done = 1'b0;
					n.converted = 1'b0;
					if (r.start) begin
						// low-power: this read returns the last conversion
						n.start = 1'b0;
						n.cnt = ACQ_LOAD;
						n.state = H_ACQ;
					end else begin
						n.start = 1'b1;
						n.converted = 1'b1;
						n.cnt = START_PULSE_LOAD;
						n.state = H_START_PULSE;
					end
				end
			end
			H_ACQ: begin
				if (r.cnt != '0) begin
					n.cnt = r.cnt - CW'(1);
				end else if (r.fast && !r.converted) begin
					n.start = 1'b1;
					n.converted = 1'b1;
					n.cnt = START_PULSE_LOAD;
					n.state = H_START_PULSE;
				end else begin
					n.sck = 1'b0;
					n.bits = '0;
					n.cnt = HALF_LOAD;
					n.state = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (r.cnt != '0) begin
					n.cnt = r.cnt - CW'(1);
				end else begin
					n.cnt = HALF_LOAD;
					if (r.sck) begin
						n.sck = 1'b0;
					end else if (r.bits == BITS_END) begin
						push = 1'b1;
						n.read_done = 1'b1;
						if (r.fast) begin
							n.state = H_IDLE;
						end else begin
							n.start = 1'b1;
							n.cnt = START_PULSE_LOAD;
							n.state = H_START_PULSE;
						end
					end else begin
						n.sck = 1'b1;
						n.shreg = {r.shreg[FRAME-2:0], r.sdo_sync};
						n.bits = r.bits + FCW'(1);
					end
				end
			end
			H_START_PULSE: begin
				// shift clock stays low throughout
				n.sck = 1'b0;
				if (r.cnt != '0) begin
					n.cnt = r.cnt - CW'(1);
				end else if (r.read_done) begin
					n.state = H_IDLE;
				end else begin
					n.start = 1'b0;
					n.cnt = ACQ_LOAD;
					n.state = H_ACQ;
				end
			end
			default: begin
				n.state = H_IDLE;
			end
		endcase
		if (push) begin
			n.mem[r.wr_ptr] = r.shreg[FRAME-1 -: WORD_W];
			n.wr_ptr = r.wr_ptr + PTR_W'(1);
		end
		if (pop) begin
			n.rd_ptr = r.rd_ptr + PTR_W'(1);
		end
		case ({push, pop})
			2'b10:   n.fill = r.fill + (PTR_W + 1)'(1);
			2'b01:   n.fill = r.fill - (PTR_W + 1)'(1);
			default: n.fill = r.fill;
		endcase
		if (!i_reset_n) begin
			n = '0;
			n.state = H_IDLE;
			n.start = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		r <= n;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// a full buffer refuses requests, so a stalled reader loses nothing
	assign o_req_ready      = (r.state == H_IDLE) && (r.fill != FILL_FULL);
	assign o_word_valid     = r.fill != '0;
	assign o_word_data      = r.mem[r.rd_ptr];
	assign link.sck         = r.sck;
	assign link.start_pulse = r.start;

endmodule

/* File: tb/sar_adc_link_asserts.sv */
`timescale 1ns/1ps
module sar_adc_link_asserts (
	input  wire logic i_clk_sys,
	input  wire logic i_clk_link,
	input  wire logic i_reset_n,
	input  wire logic sck,
	input  wire logic start_pulse,
	input  wire logic serial_result_out,
	input  wire logic serial_result_oe_n,
	input  wire logic serial_result_line
);
	// ---------------------------------------------------------------
	// shift clock falls seen since start went low
	// ---------------------------------------------------------------
	logic       sck_reg;
	logic [4:0] falls_reg;

	// start high clears the count, as it clears the device's bit index
	always_ff @(posedge i_clk_link) begin
		sck_reg <= sck;
		if (start_pulse)
			falls_reg <= 5'h00;
		else if (sck_reg && !sck && falls_reg != 5'h1f)
			falls_reg <= falls_reg + 5'h01;
	end

	// ---------------------------------------------------------------
	// link checks
	// ---------------------------------------------------------------
	release_on_start_a: assert property (
		@(posedge i_clk_link) disable iff (!i_reset_n)
		$rose(start_pulse) |-> ##[1:4] serial_result_oe_n)
		else $error("output not released after start rose");
	stay_released_a: assert property (
		@(posedge i_clk_link) disable iff (!i_reset_n)
		start_pulse [*5] |-> serial_result_oe_n)
		else $error("output driven while start high");
	drive_on_fall_a: assert property (
		@(posedge i_clk_link) disable iff (!i_reset_n)
		$fell(start_pulse) |-> ##[1:4] !serial_result_oe_n)
		else $error("output not driven after start fell");
	shift_on_fall_a: assert property (
		@(posedge i_clk_link) disable iff (!i_reset_n)
		(!serial_result_oe_n && !$past(serial_result_oe_n) &&
		$changed(serial_result_out)) |-> !sck)
		else $error("data bit changed while shift clock high");
	// start high clears the index at once, before the enable drops
	zero_tail_a: assert property (
		@(posedge i_clk_link) disable iff (!i_reset_n)
		(falls_reg >= 5'h0c && !start_pulse && !serial_result_oe_n) |->
		!serial_result_line)
		else $error("nonzero bit after the twelve data bits");
	sck_still_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		start_pulse |-> !sck)
		else $error("shift clock high while start high");
	acq_low_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		$fell(start_pulse) |-> !start_pulse [*5])
		else $error("start low shorter than acquisition time");
	start_pulse_hold_a: assert property (
		@(posedge i_clk_sys) disable iff (!i_reset_n)
		$rose(start_pulse) |-> start_pulse [*8] ##1 start_pulse [*8] ##1
		start_pulse [*2])
		else $error("start high shorter than a conversion");
endmodule

/* File: tb/sar_adc_serial_readout_tb.sv */
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
	typedef logic signed [sar_adc_pkg::ANALOG_W-1:0] level_t;
	typedef logic [sar_adc_pkg::RESULT_BITS-1:0]     code_t;

	logic        i_clk_sys;
	logic        i_clk_link;
	logic        i_reset_n;
	level_t      level;
	logic        req_valid;
	logic        req_fast;
	logic        req_ready;
	logic        word_valid;
	logic        word_ready;
	code_t       word_data;
	code_t       dv_result;
	logic        dv_busy;
	logic        dv_sleeping;
	logic        dv_tracking;
	logic        dv_overrange;
	logic        dv_enabled;
	logic [15:0] dv_count;
	code_t       held;
	code_t       exp_q[$];
	logic [15:0] start_pulse_exp;
	logic        ovr_exp;
	bit          ok;
	bit          start_low;
	int          error_cnt;
	int          comparisons;
	level_t      lvls[5] = '{14'sh0123, 14'sh3ffb, 14'sh1400, 14'sh0fff,
		14'sh0000};

	sar_adc_link_if link_bus ();

	sar_adc_device i_sar_adc_device (
		.i_clk_sys        (i_clk_link),
		.i_reset_n        (i_reset_n),
		.link             (link_bus),
		.i_analog_level   (level),
		.o_result         (dv_result),
		.o_busy           (dv_busy),
		.o_sleeping       (dv_sleeping),
		.o_tracking       (dv_tracking),
		.o_overrange      (dv_overrange),
		.o_output_enabled (dv_enabled),
		.o_start_pulse_count     (dv_count)
	);

	sar_adc_host i_sar_adc_host (
		.i_clk_sys    (i_clk_sys),
		.i_reset_n    (i_reset_n),
		.link         (link_bus),
		.i_req_valid  (req_valid),
		.i_req_fast   (req_fast),
		.o_req_ready  (req_ready),
		.o_word_valid (word_valid),
		.i_word_ready (word_ready),
		.o_word_data  (word_data)
	);

	sar_adc_link_asserts chk (
		.i_clk_sys          (i_clk_sys),
		.i_clk_link         (i_clk_link),
		.i_reset_n          (i_reset_n),
		.sck                (link_bus.sck),
		.start_pulse        (link_bus.start_pulse),
		.serial_result_out  (link_bus.serial_result_out),
		.serial_result_oe_n (link_bus.serial_result_oe_n),
		.serial_result_line (link_bus.serial_result_line)
	);

	// ---------------------------------------------------------------
	// clocks: link clock free of any phase tie to the system clock
	// ---------------------------------------------------------------
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		i_clk_link = 1'b0;
		#13;
		forever #40 i_clk_link = ~i_clk_link;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic code_t clamp_code(input level_t v);
		if (v < 0)
			return 12'h000;
		if (v > 14'sh0fff)
			return 12'hfff;
		return v[11:0];
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d, mismatched %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// bounded wait for request ready; returns at the falling edge after
	task automatic wait_ready(output bit rdy);
		int n;
		n = 0;
		rdy = 1'b0;
		while (n < 3000 && !rdy) begin
			@(posedge i_clk_sys);
			rdy = (req_ready === 1'b1);
			n++;
		end
		@(negedge i_clk_sys);
	endtask

	// low-power word is the previous result, unless start idles low:
	// then the host converts first and converts again after the read
	task automatic do_req(input logic fast, input level_t lvl);
		bit taken;
		code_t code;
		level = lvl;
		req_fast = fast;
		req_valid = 1'b1;
		wait_ready(taken);
		req_valid = 1'b0;
		check(taken, 1'b1);
		code = clamp_code(lvl);
		if (fast || start_low)
			held = code;
		exp_q.push_back(held);
		held = code;
		if (!fast && start_low)
			start_pulse_exp++;
		start_pulse_exp++;
		start_low = fast;
		ovr_exp = (lvl < 0) || (lvl > 14'sh0fff);
	endtask

	task automatic settle();
		wait_ready(ok);
		check(ok, 1'b1);
		repeat (4) @(negedge i_clk_sys);
		check(dv_count, start_pulse_exp);
		check(dv_result, held);
		check(dv_overrange, ovr_exp);
		check(dv_busy, 1'b0);
		check(dv_sleeping, !req_fast);
		check(dv_tracking, req_fast);
		check(dv_enabled, req_fast);
	endtask

	task automatic pop_word();
		int n;
		n = 0;
		word_ready = 1'b1;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (word_valid !== 1'b1 && n < 500);
		check(word_valid, 1'b1);
		check(word_data, exp_q.pop_front());
		@(negedge i_clk_sys);
		word_ready = 1'b0;
		@(negedge i_clk_sys);
	endtask

	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		i_reset_n = 1'b0;
		level = 14'sh0000;
		req_valid = 1'b0;
		req_fast = 1'b0;
		word_ready = 1'b0;
		held = 12'h000;
		start_pulse_exp = 16'h0000;
		ovr_exp = 1'b0;
		start_low = 1'b0;
		error_cnt = 0;
		comparisons = 0;
		repeat (3) @(negedge i_clk_sys);
		i_reset_n = 1'b1;
		check(dv_sleeping, 1'b1);
		check(dv_enabled, 1'b0);
		check(dv_count, 16'h0000);
		$display("test reset state done");

		// in range, below ground, above full scale and both edges
		for (int i = 0; i < 5; i++) begin
			do_req(1'b0, lvls[i]);
			settle();
			pop_word();
		end
		$display("test low-power reads done");

		// reader stalled: two words queue, further requests are refused
		do_req(1'b0, 14'sh0456);
		settle();
		do_req(1'b0, 14'sh0789);
		wait_ready(ok);
		check(ok, 1'b0);
		check(word_valid, 1'b1);
		pop_word();
		pop_word();
		settle();
		$display("test stalled reader done");

		// first from start-high idle, second from start-low idle
		do_req(1'b1, 14'sh0a5c);
		settle();
		pop_word();
		do_req(1'b1, 14'sh035a);
		settle();
		pop_word();
		$display("test fast reads done");

		// low-power request while start idles low: fresh word
		do_req(1'b0, 14'sh0c3c);
		settle();
		pop_word();
		$display("test low-power from start low done");
		give_verdict();
	end

	// runs take about 5000 system cycles
	initial begin
		#3000000;
		error_cnt++;
		$display("watchdog expired at %0t", $time);
		give_verdict();
	end
endmodule
